// >>> verilog/dbpc_top.v
/*
 Control logic of a dual battery charger and source selector: serial
 command slave, charge select with watchdog, source path switching,
 autonomous diode-like mode and latched emergency switch-off.
 Assumes all pin inputs are asynchronous to mclk_i and that the serial
 clock is much slower than mclk_i (at least 4 clocks per half period).
*/
`timescale 1ns/1ps
`include "dbpc_defs.vh"

module dbpc_top #(
	parameter WDT_CYCLES = `DBPC_WDT_CYCLES
) (
	input wire mclk_i,
	input wire resetn_i,
	input wire sck_i,
	input wire mosi_i,
	input wire slave_select_n_i,
	input wire adapter_sense_input_i,
	input wire low_power_sense_i,
	input wire overvoltage_trip_i,
	input wire [2:0] source_delivering_i,
	output reg miso_o,
	output reg miso_oe_n_o,
	output reg charge_switch_gate_one_o,
	output reg charge_switch_gate_two_o,
	output reg [2:0] source_out_gate_o,
	output reg [2:0] source_in_gate_o,
	output reg adapter_present_flag_o,
	output reg diode_mode_o,
	output reg emergency_off_o,
	output reg watchdog_expired_o
);

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	reg [8:0] sync1_reg;
	reg [8:0] sync2_reg;
	wire [8:0] raw_in;
	wire sck_s;
	wire mosi_s;
	wire ss_n_s;
	wire adapter_s;
	wire lowpwr_s;
	wire ovp_s;
	wire [2:0] deliver_s;

	assign raw_in = {source_delivering_i, overvoltage_trip_i, low_power_sense_i,
		adapter_sense_input_i, slave_select_n_i, mosi_i, sck_i};
	assign {deliver_s, ovp_s, lowpwr_s, adapter_s, ss_n_s, mosi_s, sck_s} = sync2_reg;

	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sync1_reg <= 9'h004;
			sync2_reg <= 9'h004;
		end
		else
		begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
		end
	end

	// ------------------------------------------------------------------
	// Serial slave
	// ------------------------------------------------------------------
	reg sck_d_reg;
	reg [7:0] shift_reg;
	reg [2:0] bit_cnt_reg;
	reg last_bit_reg;
	reg read_act_reg;
	reg tx_bit_reg;
	wire sck_rise;
	wire sck_fall;
	wire [7:0] frame;
	wire frame_done;
	wire [2:0] frame_addr;
	wire wr_charge;
	wire wr_path;

	assign sck_rise = sck_s & ~sck_d_reg & ~ss_n_s;
	assign sck_fall = ~sck_s & sck_d_reg & ~ss_n_s;
	assign frame = {mosi_s, shift_reg[7:1]};
	assign frame_done = sck_rise && (bit_cnt_reg == 3'h7);
	assign frame_addr = frame[`DBPC_ADDR_MSB:`DBPC_ADDR_LSB];
	assign wr_charge = frame_done && !frame[`DBPC_TYPE_BIT] && (frame_addr == `DBPC_ADDR_CHARGE);
	assign wr_path = frame_done && !frame[`DBPC_TYPE_BIT] && (frame_addr == `DBPC_ADDR_PATH);

	// Status bit presented in a given slot of a read answer byte
	function status_bit;
		input [2:0] slot;
		input fault;
		input diode;
		input adapter;
		input lowpwr;
		input charging;
		begin
			case (slot)
				`DBPC_ST_FAULT: status_bit = fault;
				`DBPC_ST_DIODE: status_bit = diode;
				`DBPC_ST_ADAPTER: status_bit = adapter;
				`DBPC_ST_LOWPWR: status_bit = lowpwr;
				`DBPC_ST_CHARGE: status_bit = charging;
				default: status_bit = 1'b1;
			endcase
		end
	endfunction

	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sck_d_reg <= 1'b0;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			last_bit_reg <= 1'b1;
			read_act_reg <= 1'b0;
			tx_bit_reg <= 1'b1;
		end
		else
		begin
			sck_d_reg <= sck_s;
			if (ss_n_s)
			begin
				// Deselect aborts any partial byte
				bit_cnt_reg <= 3'h0;
				read_act_reg <= 1'b0;
				tx_bit_reg <= 1'b1;
			end
			else
			begin
				if (sck_rise)
				begin
					shift_reg <= frame;
					last_bit_reg <= mosi_s;
					bit_cnt_reg <= bit_cnt_reg + 3'h1;
					// A completed read request makes the next byte carry status
					if (frame_done)
						read_act_reg <= !frame[`DBPC_TYPE_BIT] && (frame_addr == `DBPC_ADDR_STATUS);
				end
				if (sck_fall)
				begin
					// Slot 0 still echoes the request's last bit; slots 1 to 5 carry status, slots 6 and 7 read 1
					if (read_act_reg && (bit_cnt_reg != 3'h0))
						tx_bit_reg <= status_bit(bit_cnt_reg, emergency_off_o, diode_mode_o,
							adapter_present_flag_o, lowpwr_s,
							charge_switch_gate_one_o | charge_switch_gate_two_o);
					else
						tx_bit_reg <= last_bit_reg;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Charge select and watchdog
	// ------------------------------------------------------------------
	reg [1:0] charge_sel_reg;
	reg [31:0] wdt_cnt_reg;
	wire wdt_hit;

	// Expiry wins over a refresh in the same cycle; the counter parks until the next write
	assign wdt_hit = !watchdog_expired_o && (wdt_cnt_reg >= WDT_CYCLES - 1);

	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			charge_sel_reg <= 2'h0;
			wdt_cnt_reg <= 32'h0;
			watchdog_expired_o <= 1'b0;
		end
		else if (wdt_hit)
		begin
			charge_sel_reg <= 2'h0;
			watchdog_expired_o <= 1'b1;
		end
		else if (wr_charge)
		begin
			charge_sel_reg <= frame[1:0];
			wdt_cnt_reg <= 32'h0;
			watchdog_expired_o <= 1'b0;
		end
		else if (!watchdog_expired_o)
			wdt_cnt_reg <= wdt_cnt_reg + 32'h1;
	end

	// ------------------------------------------------------------------
	// Source path control
	// ------------------------------------------------------------------
	reg [2:0] path_sel_reg;

	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			path_sel_reg <= 3'h0;
			diode_mode_o <= 1'b0;
			emergency_off_o <= 1'b0;
		end
		else
		begin
			// Only a power cycle (reset) releases the emergency latch
			if (ovp_s)
				emergency_off_o <= 1'b1;
			if (wr_path)
				path_sel_reg <= {frame[2], frame[1], frame[0]};
			// Trip wins over the host's rewrite in the same cycle
			if (lowpwr_s)
				diode_mode_o <= 1'b1;
			else if (wr_path)
				diode_mode_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Output drivers
	// ------------------------------------------------------------------
	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			miso_o <= 1'b0;
			miso_oe_n_o <= 1'b1;
			charge_switch_gate_one_o <= 1'b0;
			charge_switch_gate_two_o <= 1'b0;
			source_out_gate_o <= 3'h0;
			source_in_gate_o <= 3'h0;
			adapter_present_flag_o <= 1'b0;
		end
		else
		begin
			miso_o <= 1'b0;
			miso_oe_n_o <= ss_n_s | tx_bit_reg;
			adapter_present_flag_o <= adapter_s;
			charge_switch_gate_one_o <= charge_sel_reg[0] & adapter_s;
			charge_switch_gate_two_o <= charge_sel_reg[1] & adapter_s;
			if (emergency_off_o || ovp_s)
			begin
				source_out_gate_o <= 3'h0;
				source_in_gate_o <= 3'h0;
			end
			else if (diode_mode_o || lowpwr_s)
			begin
				source_out_gate_o <= 3'h7;
				source_in_gate_o <= deliver_s;
			end
			else
			begin
				source_out_gate_o <= path_sel_reg;
				source_in_gate_o <= path_sel_reg;
			end
		end
	end

endmodule // dbpc_top

// >>> verilog/dbpc_defs.vh
/*
 Constants of the dual battery path control block: serial frame layout,
 command addresses, status bit positions and timing.
 Assumes inclusion by bare name from the design files.
*/
`ifndef DBPC_DEFS_VH
`define DBPC_DEFS_VH

// ----------------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------------
`define DBPC_FRAME_BITS 8
`define DBPC_ADDR_LSB 4
`define DBPC_ADDR_MSB 6
`define DBPC_TYPE_BIT 7
`define DBPC_ADDR_CHARGE 3'h7
`define DBPC_ADDR_PATH 3'h6
`define DBPC_ADDR_STATUS 3'h2

// ----------------------------------------------------------------------
// Status byte positions, counted in bit slots after the byte starts
// ----------------------------------------------------------------------
`define DBPC_ST_FAULT 3'h1
`define DBPC_ST_DIODE 3'h2
`define DBPC_ST_ADAPTER 3'h3
`define DBPC_ST_LOWPWR 3'h4
`define DBPC_ST_CHARGE 3'h5

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DBPC_CLK_HZ 40000000
`define DBPC_WDT_TIME_MS 1000
`define DBPC_WDT_CYCLES ((`DBPC_CLK_HZ / 1000) * `DBPC_WDT_TIME_MS)

`endif

// >>> testbench/dbpc_checker.sv
/*
 Port assertions for the dual battery path control block.
 Assumes a bind to dbpc_top and one clock domain, mclk_i.
*/
`timescale 1ns/1ps
module dbpc_checker #(
	parameter WDT_CYCLES = 200
) (
	input wire mclk_i,
	input wire resetn_i,
	input wire slave_select_n_i,
	input wire adapter_sense_input_i,
	input wire low_power_sense_i,
	input wire miso_oe_n_o,
	input wire charge_switch_gate_one_o,
	input wire charge_switch_gate_two_o,
	input wire [2:0] source_out_gate_o,
	input wire [2:0] source_in_gate_o,
	input wire adapter_present_flag_o,
	input wire emergency_off_o,
	input wire watchdog_expired_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);
	wire chg_on = charge_switch_gate_one_o | charge_switch_gate_two_o;
	sequence lp_held;
		low_power_sense_i [*5];
	endsequence
	sequence idle_held;
		slave_select_n_i [*4];
	endsequence
	gates_off_a: assert property (emergency_off_o |-> (source_out_gate_o | source_in_gate_o) == 3'h0)
		else $error("path on while latched off");
	latch_hold_a: assert property (emergency_off_o |=> emergency_off_o)
		else $error("latch released");
	charge_adapter_a: assert property (chg_on |-> adapter_present_flag_o || $past(adapter_present_flag_o))
		else $error("charging without adapter");
	adapter_flag_a: assert property ($rose(adapter_sense_input_i) |-> ##[2:4] adapter_present_flag_o)
		else $error("adapter flag late");
	lowpwr_out_a: assert property (lp_held |-> source_out_gate_o == 3'h7 || emergency_off_o)
		else $error("low power switches off");
	miso_idle_a: assert property (idle_held |-> miso_oe_n_o)
		else $error("data pulled while idle");
	miso_pull_a: assert property ($fell(miso_oe_n_o) |-> !$past(slave_select_n_i, 3))
		else $error("data pulled unselected");
	wdt_clear_a: assert property (watchdog_expired_o |=> !chg_on)
		else $error("charging after expiry");
endmodule // dbpc_checker
bind dbpc_top dbpc_checker #(.WDT_CYCLES(WDT_CYCLES)) u_dbpc_checker (.*);

// >>> testbench/dbpc_host_model.sv
/*
 Host master model of the serial link.
 Assumes the bench resolves the open-drain data line with its pull-up.
*/
`timescale 1ns/1ps
module dbpc_host_model (
	input wire miso_line_i,
	output reg sck_o,
	output reg mosi_o,
	output reg slave_select_n_o
);
	initial
	begin
		sck_o = 1'b0;
		mosi_o = 1'b1;
		slave_select_n_o = 1'b1;
	end
	// Bit i of w goes out i-th; r[i] is sampled while the clock is high
	task frame(input [15:0] w, input integer n, output [15:0] r);
		integer i;
		begin
			r = 16'h0;
			slave_select_n_o = 1'b0;
			#200;
			for (i = 0; i < n; i = i + 1)
			begin
				mosi_o = w[i];
				#100 sck_o = 1'b1;
				#50 r[i] = miso_line_i;
				#50 sck_o = 1'b0;
			end
			#200 slave_select_n_o = 1'b1;
			// Released data line must not look like held data
			mosi_o = ~mosi_o;
			#200;
		end
	endtask
endmodule // dbpc_host_model

// >>> testbench/tb.sv
/*
 Self-checking bench for dbpc_top driven by the host model.
 Assumes a short watchdog parameter so expiry is reached quickly.
*/
`timescale 1ns/1ps
module tb;
	localparam WDT = 400;
	reg mclk_i = 1'b0;
	reg resetn_i = 1'b0;
	reg adapter_sense_input_i = 1'b0;
	reg low_power_sense_i = 1'b0;
	reg overvoltage_trip_i = 1'b0;
	reg [2:0] source_delivering_i = 3'h0;
	wire sck_i, mosi_i, slave_select_n_i, miso_o, miso_oe_n_o;
	wire charge_switch_gate_one_o, charge_switch_gate_two_o, adapter_present_flag_o;
	wire diode_mode_o, emergency_off_o, watchdog_expired_o;
	wire [2:0] source_out_gate_o, source_in_gate_o;
	wire miso_line = miso_oe_n_o ? 1'b1 : miso_o;
	wire [7:0] chg = {5'h0, watchdog_expired_o, charge_switch_gate_two_o, charge_switch_gate_one_o};
	wire [7:0] path = {diode_mode_o, emergency_off_o, source_out_gate_o, source_in_gate_o};
	reg [15:0] rd;
	integer n_mismatch = 0;
	integer cmp_count = 0;
	always #12.5 mclk_i = ~mclk_i;
	dbpc_top #(.WDT_CYCLES(WDT)) u_dbpc_top (.*);
	dbpc_host_model u_dbpc_host_model (.miso_line_i(miso_line), .sck_o(sck_i), .mosi_o(mosi_i),
		.slave_select_n_o(slave_select_n_i));
	task chk(input [7:0] got, input [7:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp)
			begin
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
				n_mismatch = n_mismatch + 1;
			end
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge mclk_i);
			#1;
		end
	endtask
	task wr(input [2:0] a, input [2:0] d);
		begin
			u_dbpc_host_model.frame({9'h0, a, 1'b0, d}, 8, rd);
			chk(rd[7:0], {a, 1'b0, d, 1'b1});
			cyc(2);
		end
	endtask
	// Status slots: charge, low power, adapter, diode, fault
	task st(input [4:0] exp);
		begin
			u_dbpc_host_model.frame(16'ha020, 16, rd);
			chk(rd[7:0], 8'h41);
			chk(rd[15:8], {2'h3, exp, 1'b0});
			cyc(2);
		end
	endtask
	task t_charge;
		begin
			adapter_sense_input_i = 1'b1;
			wr(3'h7, 3'h3);
			chk({adapter_present_flag_o, chg[6:0]}, 8'h83);
			st(5'h14);
			adapter_sense_input_i = 1'b0;
			cyc(6);
			chk({adapter_present_flag_o, chg[6:0]}, 8'h00);
			adapter_sense_input_i = 1'b1;
			cyc(6);
			chk(chg, 8'h03);
			cyc(WDT);
			chk(chg, 8'h04);
			wr(3'h7, 3'h1);
			chk(chg, 8'h01);
		end
	endtask
	task t_path;
		integer p;
		begin
			for (p = 1; p < 8; p = p + 1)
			begin
				wr(3'h6, p[2:0]);
				chk(path, {2'h0, p[2:0], p[2:0]});
			end
			wr(3'h5, 3'h1);
			chk(path, 8'h3f);
			u_dbpc_host_model.frame(16'h00e1, 8, rd);
			cyc(2);
			chk(path, 8'h3f);
			u_dbpc_host_model.frame(16'h0061, 7, rd);
			cyc(2);
			chk(path, 8'h3f);
		end
	endtask
	task t_lowpwr;
		begin
			wr(3'h6, 3'h4);
			source_delivering_i = 3'h4;
			low_power_sense_i = 1'b1;
			cyc(6);
			chk(path, 8'hbc);
			st(5'h0e);
			low_power_sense_i = 1'b0;
			wr(3'h6, 3'h1);
			chk(path, 8'h09);
		end
	endtask
	task t_emerg;
		begin
			low_power_sense_i = 1'b1;
			overvoltage_trip_i = 1'b1;
			cyc(6);
			overvoltage_trip_i = 1'b0;
			wr(3'h6, 3'h2);
			chk(path, 8'hc0);
			st(5'h0f);
		end
	endtask
	task t_reset;
		begin
			low_power_sense_i = 1'b0;
			resetn_i = 1'b0;
			cyc(3);
			resetn_i = 1'b1;
			cyc(3);
			chk(path, 8'h00);
			chk({adapter_present_flag_o, chg[6:0]}, 8'h80);
			wr(3'h6, 3'h2);
			chk(path, 8'h12);
		end
	endtask
	task finish_test;
		begin
			if (n_mismatch == 0 && cmp_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial
	begin
		cyc(3);
		resetn_i = 1'b1;
		cyc(3);
		t_charge;
		t_path;
		t_lowpwr;
		t_emerg;
		t_reset;
		finish_test;
	end
	initial
	begin
		#2000000;
		n_mismatch = n_mismatch + 1;
		finish_test;
	end
endmodule // tb
